// ---- rtl/circ_buffer.sv ----
// Circular measurement buffer of the 50 latest samples with stop delay
`timescale 1ns/1ns
module circ_buffer
	import hsw_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [9:0] sample,
	input  wire logic       sampleValid,
	input  wire logic       runEn,
	input  wire logic       res10,
	input  wire logic       shutdown,
	input  wire logic [5:0] stopDelay,
	input  wire logic [5:0] rdIndex,
	output logic      [9:0] rdData,
	output logic            running
);
	logic [9:0] mem [BUF_DEPTH];
	logic [5:0] wrPtr;
	logic [5:0] postCnt;
	logic       draining;
	logic       stopped;
	logic [6:0] sum;
	logic [5:0] rdPtr;
	logic       doWrite;

	assign running = runEn & ~stopped; // RL17 RL24
	assign doWrite = sampleValid & running;

	// Storage; 8-bit mode keeps the top bits of the sample
	always_ff @(posedge clk) begin
		if (doWrite) begin
			mem[wrPtr] <= res10 ? sample : {2'h0, sample[9:2]}; // RL18
		end
	end

	// Write pointer wraps so the oldest entry is overwritten
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr <= 6'h00;
		end else if (doWrite) begin
			wrPtr <= (wrPtr == 6'(BUF_DEPTH - 1)) ? 6'h00 : wrPtr + 6'h01; // RL22
		end
	end

	// Post-shutdown countdown; clearing runEn rearms the buffer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stopped <= 1'b0;
			draining <= 1'b0;
			postCnt <= 6'h00;
		end else if (!runEn) begin
			stopped <= 1'b0;
			draining <= 1'b0;
		end else if (shutdown && !draining && !stopped) begin
			stopped <= (stopDelay == 6'h00); // RL16
			draining <= (stopDelay != 6'h00);
			postCnt <= stopDelay;
		end else if (draining && sampleValid) begin
			postCnt <= postCnt - 6'h01;
			if (postCnt == 6'h01) begin
				stopped <= 1'b1; // RL16
				draining <= 1'b0;
			end
		end
	end

	// Index 0 is the oldest entry
	assign sum = {1'b0, wrPtr} + {1'b0, rdIndex};
	assign rdPtr = (sum >= 7'(BUF_DEPTH)) ? 6'(sum - 7'(BUF_DEPTH)) : sum[5:0];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData <= 10'h000;
		end else begin
			rdData <= (rdIndex < 6'(BUF_DEPTH)) ? mem[rdPtr] : 10'h000;
		end
	end
endmodule

// ---- rtl/hot_swap_ctrl.sv ----
// Dual hot-swap channel control, limits, tracking, buffers and LED pins
//
// Behaviour
// RL1: Channel on when its input-valid bit is 1 and either enable bit is 1.
// RL2: At startup second enable bits follow the hardware-enable strap level.
// RL3: Retry strap high selects auto-retry, low selects latch-off after faults.
// RL4: Per channel, a field selects 2, 4, 8 or 16 V voltage range.
// RL5: Per channel, four 10-bit voltage limits: OV critical/warning, UV warning/critical.
// RL6: Per channel, one 10-bit overcurrent warning limit.
// RL7: Per channel, current-sense range selects 25, 50 or 100 mV.
// RL8: Per channel, 8-bit fast-trip threshold, legal 102 to 255.
// RL9: Per channel, two-bit fast-to-slow trip ratio, 125 to 200 percent.
// RL10: Power-good asserts after a selectable 50, 100, 200 or 400 ms.
// RL11: With deglitch on, a fault needs two consecutive failing comparisons.
// RL12: Reset control clears the channel's min and max tracking registers.
// RL13: Hold control freezes the channel's min and max tracking registers.
// RL14: Force-on works only with key enable set, then turns channel on.
// RL15: Clear-alert command clears the alert bit and releases the alert pin.
// RL16: After shutdown, each running buffer records 0 to 50 more samples, then stops; the 6-bit stop delay field here accepts up to 63.
// RL17: Voltage and current buffers have independent enables per channel.
// RL18: Each buffer stores 8-bit or 10-bit samples by its resolution setting.
// RL19: A per-pin set control turns each open-drain LED driver on.
// RL20: Per-pin flash makes an active LED blink; phase inverts its blink.
// RL21: A per-pin control switches on a weak pull-up on each LED pin.
// RL22: Each buffer keeps the 50 latest samples, overwriting the oldest.
// RL23: After startup only register writes change the second enable bit.
// RL24: A stopped buffer records nothing new and keeps its contents.
// RL25: Limit crossings set fault status bits and raise alert bit and pin.
// RL26: All registers reachable by single register reads and writes.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module hot_swap_ctrl #(
	parameter int unsigned PG_UNIT_CYC = hsw_pkg::PG_UNIT_CYCLES,
	parameter int unsigned FLASH_CYC   = hsw_pkg::FLASH_HALF_CYCLES,
	parameter int unsigned RETRY_CYC   = hsw_pkg::RETRY_CYCLES
) (
	input  wire logic                                     clk,
	input  wire logic                                     rst_b,
	input  wire logic [7:0]                               paddr,
	input  wire logic                                     psel,
	input  wire logic                                     penable,
	input  wire logic                                     pwrite,
	input  wire logic [31:0]                              pwdata,
	output logic      [31:0]                              prdata,
	output logic                                          pready,
	output logic                                          pslverr,
	input  wire logic                                     input_valid_bit_ch1,
	input  wire logic                                     input_valid_bit_ch2,
	input  wire logic                                     hardware_enable_strap,
	input  wire logic                                     retryStrap,
	input  wire logic [hsw_pkg::NUM_CH-1:0][9:0]          voltSample,
	input  wire logic [hsw_pkg::NUM_CH-1:0][9:0]          currSample,
	input  wire logic                                     sampleValid,
	output logic      [hsw_pkg::NUM_CH-1:0]               chanOn,
	output logic      [hsw_pkg::NUM_CH-1:0]               power_good_out,
	output logic                                          alertOut,
	output logic                                          alertOe,
	output logic      [hsw_pkg::NUM_LED-1:0]              ledOut,
	output logic      [hsw_pkg::NUM_LED-1:0]              ledOe,
	output logic      [hsw_pkg::NUM_LED-1:0]              ledPullup,
	output logic      [hsw_pkg::NUM_CH-1:0][1:0]          voltRange,
	output logic      [hsw_pkg::NUM_CH-1:0][1:0]          currRange,
	output logic      [hsw_pkg::NUM_CH-1:0][7:0]          fastTripThr,
	output logic      [hsw_pkg::NUM_CH-1:0][1:0]          tripRatio,
	output logic                                          retryMode
);
	import hsw_pkg::*;

	logic [3:0]                           syncA;
	logic [3:0]                           syncB;
	logic [1:0]                           strapCnt;
	logic                                 strapLoad;
	logic [NUM_CH-1:0]                    onBit;
	logic [NUM_CH-1:0]                    en1, en2, forceOn, mmReset, mmHold;
	logic [NUM_CH-1:0]                    vbufEn, ibufEn, vbufRes, ibufRes;
	logic [NUM_CH-1:0][1:0]               pgSel;
	logic [NUM_CH-1:0][NUM_LIM-1:0]       deglitch, faultStat, faultHit;
	logic [NUM_CH-1:0][NUM_LIM-1:0][9:0]  limit;
	logic [NUM_CH-1:0][9:0]               vMin, vMax, iMin, iMax;
	logic [NUM_CH-1:0]                    latched, critHit, vRun, iRun;
	logic [NUM_CH-1:0][31:0]              timer;
	logic [NUM_CH-1:0]                    next_chanOn;
	logic                                 forceKeyEn;
	logic                                 alert;
	logic [5:0]                           stopDelay;
	logic [NUM_LED-1:0]                   ledSet, ledFlash, ledPhase;
	logic [31:0]                          flashCnt;
	logic                                 blink;
	logic [5:0]                           bufIdx;
	logic [1:0]                           bufSel;
	logic [3:0][9:0]                      bufData;
	logic                                 wrEn;
	logic                                 setupRd;
	logic [31:0]                          rdVal;
	logic                                 rdErr;

	// Match an address against a register of a given channel
	function automatic logic regHit(input logic [7:0] a, input logic [7:0] off, input int ch);
		regHit = (a == off + ((ch != 0) ? CH_STRIDE : 8'h00));
	endfunction

	// Zero wait states; writes land at the access edge
	assign pready = 1'b1;
	assign wrEn = psel & penable & pwrite; // RL26
	assign setupRd = psel & ~penable;

	// Two-flop synchronisers for pins from outside the clock domain
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			syncA <= 4'h0;
			syncB <= 4'h0;
		end else begin
			syncA <= {retryStrap, hardware_enable_strap, input_valid_bit_ch2, input_valid_bit_ch1};
			syncB <= syncA;
		end
	end
	assign onBit = syncB[1:0];

	// Straps are sampled once, after the synchronisers hold real pin levels
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			strapCnt <= 2'h0;
		end else if (strapCnt != STRAP_DONE_CNT) begin
			strapCnt <= strapCnt + 2'h1;
		end
	end
	assign strapLoad = (strapCnt == STRAP_LOAD_CNT);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			retryMode <= 1'b0;
		end else if (strapLoad) begin
			retryMode <= syncB[3]; // RL3
		end
	end

	// Per-channel control and limit registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en1 <= '0;
			en2 <= '0;
			forceOn <= '0;
			mmReset <= '0;
			mmHold <= '0;
			voltRange <= '0;
			currRange <= '0;
			tripRatio <= '0;
			pgSel <= '0;
			deglitch <= '0;
			vbufEn <= '0;
			ibufEn <= '0;
			vbufRes <= '0;
			ibufRes <= '0;
			fastTripThr <= {NUM_CH{FAST_TRIP_RST}};
			for (int c = 0; c < NUM_CH; c++) begin
				limit[c][LIM_OVC] <= LIM_HI_RST;
				limit[c][LIM_OVW] <= LIM_HI_RST;
				limit[c][LIM_UVW] <= LIM_LO_RST;
				limit[c][LIM_UVC] <= LIM_LO_RST;
				limit[c][LIM_OCW] <= LIM_HI_RST;
			end
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (wrEn && regHit(paddr, OFF_CTRL, c)) begin
					en1[c] <= pwdata[CTRL_EN1];
					en2[c] <= pwdata[CTRL_EN2]; // RL23
					forceOn[c] <= pwdata[CTRL_FORCE];
					mmReset[c] <= pwdata[CTRL_MMRST];
					mmHold[c] <= pwdata[CTRL_HOLD];
					voltRange[c] <= pwdata[CTRL_VRANGE +: 2]; // RL4
					currRange[c] <= pwdata[CTRL_IRANGE +: 2]; // RL7
					tripRatio[c] <= pwdata[CTRL_RATIO +: 2]; // RL9
					pgSel[c] <= pwdata[CTRL_PGSEL +: 2];
					deglitch[c] <= pwdata[CTRL_DEGL +: NUM_LIM];
					vbufEn[c] <= pwdata[CTRL_VBUF];
					ibufEn[c] <= pwdata[CTRL_IBUF];
					vbufRes[c] <= pwdata[CTRL_VRES];
					ibufRes[c] <= pwdata[CTRL_IRES];
				end
				if (strapLoad) begin
					en2[c] <= syncB[2]; // RL2
				end
				if (wrEn && regHit(paddr, OFF_LIMA, c)) begin
					limit[c][LIM_OVC] <= pwdata[9:0]; // RL5
					limit[c][LIM_OVW] <= pwdata[HI_FIELD +: 10];
				end
				if (wrEn && regHit(paddr, OFF_LIMB, c)) begin
					limit[c][LIM_UVW] <= pwdata[9:0]; // RL5
					limit[c][LIM_UVC] <= pwdata[HI_FIELD +: 10];
				end
				if (wrEn && regHit(paddr, OFF_LIMC, c)) begin
					limit[c][LIM_OCW] <= pwdata[9:0]; // RL6
					fastTripThr[c] <= pwdata[HI_FIELD +: 8]; // RL8
				end
			end
		end
	end

	// Global, LED and buffer-select registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			forceKeyEn <= 1'b0;
			stopDelay <= 6'h00;
			ledSet <= '0;
			ledFlash <= '0;
			ledPullup <= '0;
			ledPhase <= '0;
			bufIdx <= 6'h00;
			bufSel <= 2'h0;
		end else begin
			if (wrEn && paddr == OFF_GLOBAL) begin
				forceKeyEn <= pwdata[GLB_FKEY];
				stopDelay <= pwdata[GLB_STOPDLY +: 6];
			end
			if (wrEn && paddr == OFF_LED) begin
				ledSet <= pwdata[3:0];
				ledFlash <= pwdata[7:4];
				ledPullup <= pwdata[11:8]; // RL21
				ledPhase <= pwdata[15:12];
			end
			if (wrEn && paddr == OFF_BUFSEL) begin
				bufIdx <= pwdata[5:0];
				bufSel <= pwdata[7:6];
			end
		end
	end

	// Per-channel datapath: comparators, tracking, buffers, timers
	genvar g, l;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gCh
			for (l = 0; l < NUM_LIM; l++) begin : gLim
				limit_check uLim (
					.clk         (clk),
					.rst_b       (rst_b),
					.sample      ((l == LIM_OCW) ? currSample[g] : voltSample[g]),
					.sampleValid (sampleValid),
					.limit       (limit[g][l]),
					.isUpper     ((l == LIM_OVC) || (l == LIM_OVW) || (l == LIM_OCW)),
					.deglitch    (deglitch[g][l]),
					.fault       (faultHit[g][l])
				);
			end
			assign critHit[g] = faultHit[g][LIM_OVC] | faultHit[g][LIM_UVC];

			circ_buffer uVbuf (
				.clk         (clk),
				.rst_b       (rst_b),
				.sample      (voltSample[g]),
				.sampleValid (sampleValid),
				.runEn       (vbufEn[g]),
				.res10       (vbufRes[g]),
				.shutdown    (critHit[g]),
				.stopDelay   (stopDelay),
				.rdIndex     (bufIdx),
				.rdData      (bufData[2 * g]),
				.running     (vRun[g])
			);
			circ_buffer uIbuf (
				.clk         (clk),
				.rst_b       (rst_b),
				.sample      (currSample[g]),
				.sampleValid (sampleValid),
				.runEn       (ibufEn[g]),
				.res10       (ibufRes[g]),
				.shutdown    (critHit[g]),
				.stopDelay   (stopDelay),
				.rdIndex     (bufIdx),
				.rdData      (bufData[2 * g + 1]),
				.running     (iRun[g])
			);

			// Min and max tracking; reset beats hold
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					vMin[g] <= MIN_RST;
					iMin[g] <= MIN_RST;
					vMax[g] <= MAX_RST;
					iMax[g] <= MAX_RST;
				end else if (mmReset[g]) begin
					vMin[g] <= MIN_RST; // RL12
					iMin[g] <= MIN_RST;
					vMax[g] <= MAX_RST;
					iMax[g] <= MAX_RST;
				end else if (sampleValid && !mmHold[g]) begin // RL13
					if (voltSample[g] < vMin[g]) vMin[g] <= voltSample[g];
					if (voltSample[g] > vMax[g]) vMax[g] <= voltSample[g];
					if (currSample[g] < iMin[g]) iMin[g] <= currSample[g];
					if (currSample[g] > iMax[g]) iMax[g] <= currSample[g];
				end
			end

			// Critical faults shut the channel; retry frees it after a wait,
			// latch-off only when software clears both critical bits
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					latched[g] <= 1'b0;
				end else if (critHit[g]) begin
					latched[g] <= 1'b1;
				end else if (retryMode && timer[g] >= RETRY_CYC - 1) begin
					latched[g] <= 1'b0; // RL3
				end else if (!retryMode && !faultStat[g][LIM_OVC] && !faultStat[g][LIM_UVC]) begin
					latched[g] <= 1'b0; // RL3
				end
			end

			// Force-on bypasses the input-valid check but not a fault latch
			assign next_chanOn[g] = ~latched[g] & ~critHit[g]
				& ((onBit[g] & (en1[g] | en2[g])) // RL1
				| (forceKeyEn & forceOn[g])); // RL14

			// One timer serves the power-good delay and the retry wait
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					timer[g] <= 32'h0;
				end else if (critHit[g]) begin
					timer[g] <= 32'h0;
				end else if (latched[g] || (chanOn[g] && !power_good_out[g])) begin
					timer[g] <= timer[g] + 32'h1;
				end else begin
					timer[g] <= 32'h0;
				end
			end

			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					chanOn[g] <= 1'b0;
					power_good_out[g] <= 1'b0;
				end else begin
					chanOn[g] <= next_chanOn[g];
					if (!next_chanOn[g]) begin
						power_good_out[g] <= 1'b0;
					end else if (chanOn[g] && timer[g] >= (PG_UNIT_CYC << pgSel[g]) - 1) begin
						power_good_out[g] <= 1'b1; // RL10
					end
				end
			end
		end
	endgenerate

	// Sticky fault bits, write one to clear; a new fault wins the clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			faultStat <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				for (int k = 0; k < NUM_LIM; k++) begin
					if (faultHit[c][k]) begin
						faultStat[c][k] <= 1'b1; // RL25
					end else if (wrEn && regHit(paddr, OFF_STATUS, c) && pwdata[k]) begin
						faultStat[c][k] <= 1'b0;
					end
				end
			end
		end
	end

	// Alert is raised by any fault and dropped only by the clear command
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			alert <= 1'b0;
		end else if (|faultHit) begin
			alert <= 1'b1; // RL25
		end else if (wrEn && paddr == OFF_GLOBAL && pwdata[GLB_CLRALERT]) begin
			alert <= 1'b0; // RL15
		end
	end
	assign alertOut = 1'b0; // Open drain: pulls low when enabled
	assign alertOe = alert; // RL15

	// Shared blink clock for all flashing LEDs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flashCnt <= 32'h0;
			blink <= 1'b0;
		end else if (flashCnt >= FLASH_CYC - 1) begin
			flashCnt <= 32'h0;
			blink <= ~blink;
		end else begin
			flashCnt <= flashCnt + 32'h1;
		end
	end

	// Open-drain LED drivers sink current while active
	assign ledOut = '0;
	assign ledOe = ledSet & (~ledFlash | ({NUM_LED{blink}} ^ ledPhase)); // RL19 RL20

	// Read mux; unmapped addresses answer with an error and zero data
	always_comb begin
		rdVal = 32'h0;
		rdErr = 1'b0;
		if (paddr == OFF_GLOBAL) begin
			rdVal = {18'h0, stopDelay, 4'h0, retryMode, alert, 1'b0, forceKeyEn};
		end else if (paddr == OFF_LED) begin
			rdVal = {16'h0, ledPhase, ledPullup, ledFlash, ledSet};
		end else if (paddr == OFF_BUFSEL) begin
			rdVal = {24'h0, bufSel, bufIdx};
		end else if (paddr == OFF_BUFDATA) begin
			rdVal = {22'h0, bufData[bufSel]};
		end else begin
			rdErr = 1'b1;
			for (int c = 0; c < NUM_CH; c++) begin
				if (regHit(paddr, OFF_CTRL, c)) begin
					rdErr = 1'b0;
					rdVal = {10'h0, ibufRes[c], vbufRes[c], ibufEn[c], vbufEn[c], deglitch[c],
						pgSel[c], tripRatio[c], currRange[c], voltRange[c], mmHold[c],
						mmReset[c], forceOn[c], en2[c], en1[c]};
				end
				if (regHit(paddr, OFF_LIMA, c)) begin
					rdErr = 1'b0;
					rdVal = {6'h0, limit[c][LIM_OVW], 6'h0, limit[c][LIM_OVC]};
				end
				if (regHit(paddr, OFF_LIMB, c)) begin
					rdErr = 1'b0;
					rdVal = {6'h0, limit[c][LIM_UVC], 6'h0, limit[c][LIM_UVW]};
				end
				if (regHit(paddr, OFF_LIMC, c)) begin
					rdErr = 1'b0;
					rdVal = {8'h0, fastTripThr[c], 6'h0, limit[c][LIM_OCW]};
				end
				if (regHit(paddr, OFF_STATUS, c)) begin
					rdErr = 1'b0;
					rdVal = {21'h0, iRun[c], vRun[c], onBit[c], latched[c],
						power_good_out[c], chanOn[c], faultStat[c]};
				end
				if (regHit(paddr, OFF_VMM, c)) begin
					rdErr = 1'b0;
					rdVal = {6'h0, vMax[c], 6'h0, vMin[c]};
				end
				if (regHit(paddr, OFF_IMM, c)) begin
					rdErr = 1'b0;
					rdVal = {6'h0, iMax[c], 6'h0, iMin[c]};
				end
			end
		end
	end

	// Read data and error are captured in the setup cycle and held
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (setupRd) begin
			prdata <= pwrite ? 32'h0 : rdVal; // RL26
			pslverr <= rdErr;
		end
	end
endmodule

// ---- rtl/hsw_pkg.sv ----
// Shared constants of the dual hot-swap monitor and control block
package hsw_pkg;
	localparam int NUM_CH   = 2;
	localparam int NUM_LIM  = 5;
	localparam int NUM_LED  = 4;
	localparam int BUF_DEPTH = 50;
	localparam int SAMPLE_W = 10;
	// Register byte addresses, channel 1 sits one stride above channel 0
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_LIMA    = 8'h04;
	localparam logic [7:0] OFF_LIMB    = 8'h08;
	localparam logic [7:0] OFF_LIMC    = 8'h0C;
	localparam logic [7:0] OFF_STATUS  = 8'h10;
	localparam logic [7:0] OFF_VMM     = 8'h14;
	localparam logic [7:0] OFF_IMM     = 8'h18;
	localparam logic [7:0] CH_STRIDE   = 8'h20;
	localparam logic [7:0] OFF_GLOBAL  = 8'h40;
	localparam logic [7:0] OFF_LED     = 8'h44;
	localparam logic [7:0] OFF_BUFSEL  = 8'h48;
	localparam logic [7:0] OFF_BUFDATA = 8'h4C;
	// Control register field positions
	localparam int CTRL_EN1 = 0;
	localparam int CTRL_EN2 = 1;
	localparam int CTRL_FORCE = 2;
	localparam int CTRL_MMRST = 3;
	localparam int CTRL_HOLD = 4;
	localparam int CTRL_VRANGE = 5;
	localparam int CTRL_IRANGE = 7;
	localparam int CTRL_RATIO = 9;
	localparam int CTRL_PGSEL = 11;
	localparam int CTRL_DEGL = 13;
	localparam int CTRL_VBUF = 18;
	localparam int CTRL_IBUF = 19;
	localparam int CTRL_VRES = 20;
	localparam int CTRL_IRES = 21;
	localparam int HI_FIELD = 16;
	localparam int GLB_FKEY = 0;
	localparam int GLB_CLRALERT = 1;
	localparam int GLB_STOPDLY = 8;
	// Limit indices; the first two and the last are upper limits
	localparam int LIM_OVC = 0;
	localparam int LIM_OVW = 1;
	localparam int LIM_UVW = 2;
	localparam int LIM_UVC = 3;
	localparam int LIM_OCW = 4;
	// Values after reset
	localparam logic [9:0] LIM_HI_RST = 10'h3FF;
	localparam logic [9:0] LIM_LO_RST = 10'h000;
	localparam logic [7:0] FAST_TRIP_RST = 8'hFF;
	localparam logic [9:0] MIN_RST = 10'h3FF;
	localparam logic [9:0] MAX_RST = 10'h000;
	localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
	localparam logic [1:0] STRAP_DONE_CNT = 2'h3;
	// Timing at a 125 MHz clock
	localparam int CLK_HZ = 125000000;
	localparam int PG_UNIT_MS = 50;
	localparam int FLASH_HALF_MS = 500;
	localparam int RETRY_MS = 100;
	localparam int unsigned PG_UNIT_CYCLES = PG_UNIT_MS * (CLK_HZ / 1000);
	localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_MS * (CLK_HZ / 1000);
	localparam int unsigned RETRY_CYCLES = RETRY_MS * (CLK_HZ / 1000);
endpackage

// ---- rtl/limit_check.sv ----
// One limit comparator with optional two-in-a-row deglitch
`timescale 1ns/1ns
module limit_check (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [9:0] sample,
	input  wire logic       sampleValid,
	input  wire logic [9:0] limit,
	input  wire logic       isUpper,
	input  wire logic       deglitch,
	output logic            fault
);
	logic hit;
	logic seen;

	// Upper limits trip above, lower limits trip below
	assign hit = isUpper ? (sample > limit) : (sample < limit); // RL25

	// Fault pulses one cycle after the comparison that confirms it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			seen <= 1'b0;
			fault <= 1'b0;
		end else begin
			fault <= 1'b0;
			if (sampleValid) begin
				seen <= hit;
				fault <= hit & (~deglitch | seen); // RL11
			end
		end
	end
endmodule

// ---- sim/apb_host.sv ----
// Bus master model standing in for the host controller
`timescale 1ns/1ns
module apb_host (
	input  wire logic        clk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output logic      [7:0]  paddr = 8'h0,
	output logic             psel = 1'h0,
	output logic             penable = 1'h0,
	output logic             pwrite = 1'h0,
	output logic      [31:0] pwdata = 32'h0
);
	// One transfer; a hung bus returns an unknown error flag so compares fail
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'h1;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		q = prdata;
		e = (n < 50) ? pslverr : 1'hx;
		psel <= 1'h0;
		penable <= 1'h0;
		paddr <= ~a; // Released bus shows no stale address or data
		pwdata <= ~d;
	endtask
endmodule

// ---- sim/hsw_chk_sva.sv ----
// Port assertions for the hot-swap control block
`timescale 1ns/1ns
module hsw_chk (
	input wire logic            clk,
	input wire logic            rst_b,
	input wire logic [7:0]      paddr,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [31:0]     pwdata,
	input wire logic [31:0]     prdata,
	input wire logic            pready,
	input wire logic            pslverr,
	input wire logic [1:0]      chanOn,
	input wire logic [1:0]      power_good_out,
	input wire logic [3:0]      ledPullup,
	input wire logic [1:0][1:0] voltRange,
	input wire logic [1:0][7:0] fastTripThr,
	input wire logic            retryMode
);
	// Write strobe of a completed access
	wire logic wrDone = psel && penable && pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	pready_high_a: assert property (pready) else $error("pready low");
	err_data_a: assert property (pslverr |-> prdata == 32'h0)
		else $error("error read not zero");
	range_load_a: assert property (wrDone && paddr == 8'h00
		|=> voltRange[0] == $past(pwdata[6:5])) else $error("range not loaded");
	trip_load_a: assert property (wrDone && paddr == 8'h2C
		|=> fastTripThr[1] == $past(pwdata[23:16])) else $error("trip not loaded");
	pull_load_a: assert property (wrDone && paddr == 8'h44
		|=> ledPullup == $past(pwdata[11:8])) else $error("pullup not loaded");
	// Bench runs with a 20 cycle power-good unit
	pg_delay_a: assert property ($rose(power_good_out[0])
		|-> $past(chanOn[0], 19)) else $error("power good early");
	pg_chan_a: assert property (!chanOn[1] |=> !power_good_out[1])
		else $error("power good without channel");
	strap_hold_a: assert property ($past(rst_b, 4) |-> $stable(retryMode))
		else $error("retry mode moved");
endmodule
bind hot_swap_ctrl hsw_chk u_chk (.*);

// ---- sim/tb.sv ----
// Self-checking bench for the hot-swap control block
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("unexpected %0t got %h", $time, a); end end
module tb;
	import hsw_pkg::*;
	logic            clk = 1'h0;
	logic            rst_b = 1'h0;
	logic            hardware_enable_strap = 1'h1;
	logic            retryStrap = 1'h0;
	logic            input_valid_bit_ch1 = 1'h1;
	logic            input_valid_bit_ch2 = 1'h1;
	logic            sampleValid = 1'h0;
	logic [1:0][9:0] voltSample = '0;
	logic [1:0][9:0] currSample = '0;
	logic [7:0]      paddr;
	logic            psel, penable, pwrite, pready, pslverr, alertOe, e;
	logic [31:0]     pwdata, prdata, q;
	logic [1:0]      chanOn, power_good_out;
	int              error_cnt = 0;
	int              cmp_count = 0;
	always #4 clk = ~clk;
	apb_host u_host (.*);
	// Short counts keep the power-good wait inside the run
	hot_swap_ctrl #(.PG_UNIT_CYC(20), .FLASH_CYC(4), .RETRY_CYC(30)) u_dut (.clk, .rst_b,
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.input_valid_bit_ch1, .input_valid_bit_ch2, .hardware_enable_strap, .retryStrap,
		.voltSample, .currSample, .sampleValid, .chanOn, .power_good_out, .alertOut(),
		.alertOe, .ledOut(), .ledOe(), .ledPullup(), .voltRange(), .currRange(),
		.fastTripThr(), .tripRatio(), .retryMode());
	task automatic give_verdict();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(a, 1'h1, d, q, e);
		`CHK(e, 1'h0)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		u_host.xfer(a, 1'h0, 32'h0, q, e);
		`CHK(q, x)
		`CHK(e, 1'h0)
	endtask
	// One sample pulse, same value on both channels
	task automatic smp(input logic [9:0] v);
		@(posedge clk);
		voltSample <= {v, v};
		sampleValid <= 1'h1;
		@(posedge clk);
		sampleValid <= 1'h0;
	endtask
	initial begin
		logic [31:0] v;
		void'($urandom(32'h6C67));
		retryStrap <= 1'($urandom);
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		repeat (6) @(posedge clk);
		rd(OFF_CTRL, 32'h2);
		rd(OFF_GLOBAL, {28'h0, retryStrap, 3'h0});
		`CHK(chanOn, 2'h3)
		repeat (25) @(posedge clk);
		`CHK(power_good_out, 2'h3)
		hardware_enable_strap <= 1'h0;
		input_valid_bit_ch2 <= 1'h0;
		repeat (6) @(posedge clk);
		`CHK(chanOn, 2'h1)
		rd(OFF_CTRL, 32'h2);
		// Warning limit at 100 with deglitch on, samples at 500
		wr(OFF_LIMA, 32'h006403FF);
		wr(OFF_CTRL, 32'h4002);
		smp(10'h1F4);
		rd(OFF_STATUS, 32'h160);
		smp(10'h1F4);
		rd(OFF_STATUS, 32'h162);
		rd(OFF_GLOBAL, {28'h0, retryStrap, 3'h4});
		wr(OFF_GLOBAL, 32'h2);
		rd(OFF_GLOBAL, {28'h0, retryStrap, 3'h0});
		`CHK(alertOe, 1'h0)
		rd(OFF_VMM, 32'h01F401F4);
		wr(OFF_CTRL, 32'h4012);
		smp(10'h258);
		rd(OFF_VMM, 32'h01F401F4);
		wr(OFF_CTRL, 32'h400A);
		rd(OFF_VMM, 32'h000003FF);
		u_host.xfer(8'h1C, 1'h0, 32'h0, q, e);
		`CHK(q, 32'h0)
		`CHK(e, 1'h1)
		wr(OFF_LED, $urandom);
		wr(OFF_CTRL, 32'h2 | ($urandom & 32'h7E0));
		// Random limits on the second channel read back masked
		for (int i = 0; i < 3; i++) begin
			v = $urandom;
			wr(8'(OFF_LIMA + CH_STRIDE + 4 * i), v);
			rd(8'(OFF_LIMA + CH_STRIDE + 4 * i), v & ((i == 2) ? 32'h00FF03FF
				: 32'h03FF03FF));
		end
		wr(OFF_GLOBAL, 32'h1);
		wr(8'(OFF_CTRL + CH_STRIDE), 32'h4);
		repeat (2) @(posedge clk);
		`CHK(chanOn, 2'h3)
		wr(OFF_CTRL, 32'h140002);
		smp(10'h2A5);
		wr(OFF_BUFSEL, 32'h31);
		rd(OFF_BUFDATA, 32'h2A5);
		give_verdict();
	end
	// Hang guard
	initial begin
		#400000;
		error_cnt++;
		give_verdict();
	end
endmodule
